// ---- rtl/epe_arr_if.sv ----
`timescale 1ns/10ps
interface epe_arr_if;
    logic               op_valid;
    epe_pkg::epe_mode_t op_mode;
    logic [8:0]         op_idx;
    logic               op_nv;
    logic [7:0]         op_data;
    logic               redundant;
    logic [8:0]         rd_idx;
    logic [7:0]         rd_data;
    logic [7:0]         nv_data;

    modport ctl (output op_valid, op_mode, op_idx, op_nv, op_data, redundant, rd_idx,
                 input  rd_data, nv_data);
    modport arr (input  op_valid, op_mode, op_idx, op_nv, op_data, redundant, rd_idx,
                 output rd_data, nv_data);
endinterface

// ---- rtl/epe_array.sv ----
`timescale 1ns/10ps
module epe_array (
    input wire logic clk,
    input wire logic resetn,
    epe_arr_if.arr   arr
);

    typedef struct packed {
        logic [epe_pkg::ARR_BYTES-1:0][7:0] mem;
        logic [7:0]                         nv;
    } epe_arr_state_t;

    epe_arr_state_t st;
    epe_arr_state_t next_st;

    // redundant mode folds bit 8 away so the upper copy is hit as well
    function automatic logic hits(input logic [8:0] i, input logic [8:0] t,
                                  input epe_pkg::epe_mode_t m, input logic red);
        logic r;
        r = 1'b0;
        unique case (m)
            epe_pkg::EPE_BYTE_PGM,
            epe_pkg::EPE_BYTE_ERS: r = red ? (i[7:0] == t[7:0]) : (i == t);
            epe_pkg::EPE_BLK_ERS:  r = red ? (i[7] == t[7])
                                           : (i[8:7] == t[8:7]);
            epe_pkg::EPE_BULK_ERS: r = 1'b1;
        endcase
        return r;
    endfunction

    always_comb begin
        next_st = st;
        if (arr.op_valid) begin
            if (arr.op_nv) begin
                if (arr.op_mode == epe_pkg::EPE_BYTE_PGM) begin
                    next_st.nv = st.nv & arr.op_data;
                end else if (arr.op_mode == epe_pkg::EPE_BYTE_ERS) begin
                    next_st.nv = epe_pkg::ERASED;
                end
            end else begin
                for (int i = 0; i < epe_pkg::ARR_BYTES; i++) begin
                    if (hits(9'(i), arr.op_idx, arr.op_mode, arr.redundant)) begin
                        if (arr.op_mode == epe_pkg::EPE_BYTE_PGM) begin
                            next_st.mem[i] = st.mem[i] & arr.op_data;
                        end else begin
                            next_st.mem[i] = epe_pkg::ERASED;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= {{epe_pkg::ARR_BYTES{epe_pkg::ERASED}}, epe_pkg::NV_RESET};
        end else begin
            st <= next_st;
        end
    end

    // a bit reads 1 only while both copies still hold it
    assign arr.rd_data = arr.redundant
                       ? (st.mem[{1'b0, arr.rd_idx[7:0]}] & st.mem[{1'b1, arr.rd_idx[7:0]}])
                       : st.mem[arr.rd_idx];
    assign arr.nv_data = st.nv;

endmodule // epe_array

// ---- rtl/epe_ctrl.sv ----
`timescale 1ns/10ps
module epe_ctrl (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       mem_wr,
    input  wire logic       mem_rd,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0] mem_wdata,
    input  wire logic       ctl_wr,
    input  wire logic       ctl_erase_mode_hi,
    input  wire logic       ctl_erase_mode_lo,
    input  wire logic       ctl_bus_latch_enable,
    input  wire logic       ctl_hv_apply_enable,
    output logic [7:0]      mem_rdata,
    output logic            mem_ack,
    output logic            erase_mode_hi,
    output logic            erase_mode_lo,
    output logic            bus_latch_enable,
    output logic            hv_apply_enable,
    output logic [7:0]      config_shadow_reg,
    output logic            security_armed,
    output logic            ctl_refused,
    output logic            op_refused
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic               boot;
        epe_pkg::epe_mode_t mode;
        logic               latch;
        logic               hv;
        logic               cap_valid;
        logic               cap_nv;
        logic [8:0]         cap_idx;
        logic [7:0]         cap_data;
        logic               stray_wr;
        logic [7:0]         shadow;
        logic               armed;
        logic [7:0]         rdata;
        logic               ack;
        logic               op_valid;
        logic               ctl_refused;
        logic               op_refused;
    } epe_ctrl_state_t;

    epe_ctrl_state_t st;
    epe_ctrl_state_t next_st;

    epe_arr_if arr_bus ();

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic in_array(input logic [15:0] a, input logic red);
        logic r;
        r = (a >= epe_pkg::ARR_BASE) && (a <= epe_pkg::ARR_LAST);
        if (red && a[epe_pkg::HALF_BIT]) begin
            r = 1'b0;
        end
        return r;
    endfunction

    function automatic logic [8:0] to_idx(input logic [15:0] a);
        logic [15:0] d;
        d = a - epe_pkg::ARR_BASE;
        return d[8:0];
    endfunction

    // protect bits in force for the current layout
    function automatic logic [3:0] live_bp(input logic [7:0] sh);
        logic [3:0] bp;
        bp = sh[epe_pkg::SH_BP_MSB:epe_pkg::SH_BP_LSB];
        if (sh[epe_pkg::SH_REDUND]) begin
            bp[3:2] = 2'b00;
        end
        return bp;
    endfunction

    function automatic logic op_ok(input epe_pkg::epe_mode_t m, input logic nv,
                                   input logic [8:0] idx, input logic [7:0] sh,
                                   input logic armed);
        logic [3:0] bp;
        logic       ok;
        logic       sec;
        bp  = live_bp(sh);
        sec = (idx >= epe_pkg::SEC_FIRST) && (idx <= epe_pkg::SEC_LAST);
        ok  = 1'b0;
        if (nv) begin
            // whole-area erases never reach the config byte
            ok = !armed && ((m == epe_pkg::EPE_BYTE_PGM) || (m == epe_pkg::EPE_BYTE_ERS));
        end else begin
            unique case (m)
                epe_pkg::EPE_BYTE_PGM,
                epe_pkg::EPE_BYTE_ERS: ok = !bp[idx[epe_pkg::BLK_MSB:epe_pkg::BLK_LSB]]
                                            && !(armed && sec);
                epe_pkg::EPE_BLK_ERS:  ok = !bp[idx[epe_pkg::BLK_MSB:epe_pkg::BLK_LSB]]
                                            && !armed;
                epe_pkg::EPE_BULK_ERS: ok = (bp == 4'h0) && !armed;
            endcase
        end
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic       redundant;
    logic       wr_arr;
    logic       wr_nv;
    logic       rd_arr;
    logic       rd_nv;
    logic [8:0] acc_idx;

    always_comb begin
        redundant = st.shadow[epe_pkg::SH_REDUND];
        wr_arr    = mem_wr && in_array(mem_addr, redundant);
        wr_nv     = mem_wr && (mem_addr == epe_pkg::NV_ADDR);
        rd_arr    = mem_rd && in_array(mem_addr, redundant);
        rd_nv     = mem_rd && (mem_addr == epe_pkg::NV_ADDR);
        acc_idx   = to_idx(mem_addr);
    end

    always_comb begin
        next_st          = st;
        next_st.ack      = 1'b0;
        next_st.op_valid = 1'b0;

        // shadow load once after reset
        if (st.boot) begin
            next_st.boot   = 1'b0;
            next_st.shadow = arr_bus.nv_data;
            if (!arr_bus.nv_data[epe_pkg::SH_SEC]) begin
                next_st.armed = 1'b1;
            end
        end

        // array and config byte writes
        if (st.latch && (wr_arr || wr_nv)) begin
            next_st.cap_valid = 1'b1;
            next_st.cap_nv    = wr_nv;
            next_st.cap_idx   = wr_nv ? 9'h000 : acc_idx;
            next_st.cap_data  = mem_wdata;
        end else if (mem_wr && !st.latch && !wr_arr && !wr_nv) begin
            next_st.stray_wr = 1'b1;
        end

        // reads
        if (rd_nv) begin
            next_st.rdata  = arr_bus.nv_data;
            next_st.ack    = 1'b1;
            next_st.shadow = arr_bus.nv_data;
            if (!arr_bus.nv_data[epe_pkg::SH_SEC]) begin
                next_st.armed = 1'b1;
            end
        end else if (rd_arr) begin
            next_st.ack = 1'b1;
            if (st.latch && st.cap_valid && (st.cap_nv || (st.cap_idx != acc_idx))) begin
                next_st.rdata = st.cap_data;
            end else begin
                next_st.rdata = arr_bus.rd_data;
            end
        end else if (mem_rd) begin
            next_st.rdata = epe_pkg::RD_NONE;
        end

        // control register writes
        if (ctl_wr) begin
            if (st.latch && !st.cap_valid) begin
                next_st.ctl_refused = 1'b1;
            end else begin
                next_st.ctl_refused = 1'b0;
                if (st.hv) begin
                    // latch held while voltage may still be up
                    next_st.hv = ctl_hv_apply_enable;
                end else begin
                    next_st.mode  = epe_pkg::epe_mode_t'({ctl_erase_mode_hi, ctl_erase_mode_lo});
                    next_st.latch = ctl_bus_latch_enable;
                    if (!ctl_bus_latch_enable) begin
                        next_st.cap_valid = 1'b0;
                    end else begin
                        // a stray write landing with this control write still counts
                        next_st.stray_wr = mem_wr && !st.latch && !wr_arr && !wr_nv;
                    end
                    if (ctl_hv_apply_enable) begin
                        if (st.latch && ctl_bus_latch_enable && st.cap_valid && !st.stray_wr
                            && op_ok(next_st.mode, st.cap_nv, st.cap_idx,
                                     st.shadow, st.armed)) begin
                            next_st.hv         = 1'b1;
                            next_st.op_valid   = 1'b1;
                            next_st.op_refused = 1'b0;
                        end else begin
                            next_st.op_refused = 1'b1;
                        end
                    end
                end
                // mode stays as it was while voltage is applied
                if (st.hv) begin
                    next_st.mode = st.mode;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '{boot: 1'b1, mode: epe_pkg::EPE_BYTE_PGM, cap_idx: 9'h000,
                    cap_data: 8'h00, shadow: epe_pkg::SHADOW_RST, rdata: 8'h00,
                    default: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // array

    assign arr_bus.op_valid  = st.op_valid;
    assign arr_bus.op_mode   = st.mode;
    assign arr_bus.op_idx    = st.cap_idx;
    assign arr_bus.op_nv     = st.cap_nv;
    assign arr_bus.op_data   = st.cap_data;
    assign arr_bus.redundant = st.shadow[epe_pkg::SH_REDUND];
    assign arr_bus.rd_idx    = acc_idx;

    epe_array u_array (
        .clk    (clk),
        .resetn (resetn),
        .arr    (arr_bus.arr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign mem_rdata         = st.rdata;
    assign mem_ack           = st.ack;
    assign erase_mode_hi     = st.mode[1];
    assign erase_mode_lo     = st.mode[0];
    assign bus_latch_enable  = st.latch;
    assign hv_apply_enable   = st.hv;
    assign config_shadow_reg = st.shadow;
    assign security_armed    = st.armed;
    assign ctl_refused       = st.ctl_refused;
    assign op_refused        = st.op_refused;

endmodule // epe_ctrl

// ---- rtl/epe_pkg.sv ----
package epe_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // address map
    localparam logic [15:0] ARR_BASE  = 16'h0800;
    localparam logic [15:0] ARR_LAST  = 16'h09ff;
    localparam logic [15:0] NV_ADDR   = 16'hfe1c;
    localparam int          IDX_W     = 9;
    localparam int          ARR_BYTES = 512;
    localparam int          BLK_MSB   = 8;
    localparam int          BLK_LSB   = 7;
    localparam int          HALF_BIT  = 8;

    ////////////////////////////////////////////////////////////////////////////
    // secured range, as array index
    localparam logic [8:0] SEC_FIRST = 9'h0f0;
    localparam logic [8:0] SEC_LAST  = 9'h0ff;

    ////////////////////////////////////////////////////////////////////////////
    // configuration byte layout
    localparam int SH_REDUND = 7;
    localparam int SH_SEC    = 4;
    localparam int SH_BP_MSB = 3;
    localparam int SH_BP_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////
    // values
    localparam logic [7:0] ERASED     = 8'hff;
    localparam logic [7:0] NV_RESET   = 8'hff;
    localparam logic [7:0] SHADOW_RST = 8'hff;
    localparam logic [7:0] RD_NONE    = 8'h00;

    typedef enum logic [1:0] {
        EPE_BYTE_PGM = 2'b00,
        EPE_BYTE_ERS = 2'b01,
        EPE_BLK_ERS  = 2'b10,
        EPE_BULK_ERS = 2'b11
    } epe_mode_t;

endpackage

// ---- verification/epe_cpu_model.sv ----
`timescale 1ns/10ps
module epe_cpu_model (
    input wire logic        clk,
    output logic            mem_wr,
    output logic            mem_rd,
    output logic [15:0]     mem_addr,
    output logic [7:0]      mem_wdata,
    output logic            ctl_wr,
    output logic            ctl_erase_mode_hi,
    output logic            ctl_erase_mode_lo,
    output logic            ctl_bus_latch_enable,
    output logic            ctl_hv_apply_enable,
    input wire logic [7:0]  mem_rdata,
    input wire logic        mem_ack,
    input wire logic        op_refused
);
    initial begin
        {mem_wr, mem_rd, mem_addr, mem_wdata, ctl_wr, ctl_erase_mode_hi, ctl_erase_mode_lo} = '0;
        {ctl_bus_latch_enable, ctl_hv_apply_enable} = '0;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        {mem_addr, mem_wdata, mem_wr} = {a, d, 1'b1};
        @(posedge clk) #1;
        {mem_wr, mem_wdata} = {1'b0, ~d};
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic k);
        @(posedge clk) #1;
        {mem_addr, mem_rd} = {a, 1'b1};
        @(posedge clk) #1;
        mem_rd = 1'b0;
        {d, k} = {mem_rdata, mem_ack};
    endtask
    task automatic ctl(input logic [1:0] m, input logic lat, input logic hv);
        @(posedge clk) #1;
        {ctl_erase_mode_hi, ctl_erase_mode_lo} = m;
        {ctl_bus_latch_enable, ctl_hv_apply_enable, ctl_wr} = {lat, hv, 1'b1};
        @(posedge clk) #1;
        ctl_wr = 1'b0;
    endtask
    // mode and latch, write, enable, hold, drop enable, drop latch
    task automatic op(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d, output logic r);
        ctl(m, 1'b1, 1'b0);
        wr(a, d);
        ctl(m, 1'b1, 1'b1);
        r = op_refused;
        repeat (4) @(posedge clk);
        ctl(m, 1'b0, 1'b0);
        ctl(m, 1'b0, 1'b0);
    endtask
endmodule // epe_cpu_model

// ---- verification/epe_ctrl_asserts.sv ----
`timescale 1ns/10ps
module epe_ctrl_asserts (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        mem_rd,
    input wire logic [15:0] mem_addr,
    input wire logic        ctl_wr,
    input wire logic        ctl_erase_mode_hi,
    input wire logic        ctl_erase_mode_lo,
    input wire logic        ctl_bus_latch_enable,
    input wire logic        ctl_hv_apply_enable,
    input wire logic        mem_ack,
    input wire logic        erase_mode_hi,
    input wire logic        erase_mode_lo,
    input wire logic        bus_latch_enable,
    input wire logic        hv_apply_enable,
    input wire logic [7:0]  config_shadow_reg,
    input wire logic        security_armed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic lo_half;
    logic up_half;
    assign lo_half = mem_addr >= epe_pkg::ARR_BASE && mem_addr < epe_pkg::ARR_BASE + 16'h0100;
    assign up_half = mem_addr > epe_pkg::ARR_BASE + 16'h00ff && mem_addr <= epe_pkg::ARR_LAST;
    ////////////////////////////////////////////////////////////////////////////
    property p_ack; mem_rd && lo_half |=> mem_ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack for lower half read");
    property p_upper; mem_rd && up_half && config_shadow_reg[7] |=> !mem_ack; endproperty
    a_upper: assert property (p_upper) else $error("upper half answered in redundant mode");
    property p_hv_latch; $rose(hv_apply_enable) |-> $past(bus_latch_enable) && bus_latch_enable; endproperty
    a_hv_latch: assert property (p_hv_latch) else $error("voltage applied without latch");
    property p_clr_both;
        ctl_wr && hv_apply_enable && !ctl_hv_apply_enable && !ctl_bus_latch_enable
            |=> !hv_apply_enable && bus_latch_enable;
    endproperty
    a_clr_both: assert property (p_clr_both) else $error("latch cleared with enable");
    property p_freeze; ctl_wr && hv_apply_enable |=> $stable({erase_mode_hi, erase_mode_lo}); endproperty
    a_freeze: assert property (p_freeze) else $error("mode changed under voltage");
    property p_bulk;
        $rose(hv_apply_enable) && erase_mode_hi && erase_mode_lo
            |-> (config_shadow_reg[7] ? config_shadow_reg[1:0] == 2'h0 : config_shadow_reg[3:0] == 4'h0);
    endproperty
    a_bulk: assert property (p_bulk) else $error("bulk erase with protection set");
    property p_sec_erase; $rose(hv_apply_enable) && erase_mode_hi |-> !security_armed; endproperty
    a_sec_erase: assert property (p_sec_erase) else $error("block or bulk erase while secured");
    property p_sticky; security_armed |=> security_armed; endproperty
    a_sticky: assert property (p_sticky) else $error("security dropped");
    property p_arm;
        mem_rd && mem_addr == epe_pkg::NV_ADDR |=> security_armed || config_shadow_reg[epe_pkg::SH_SEC];
    endproperty
    a_arm: assert property (p_arm) else $error("security bit zero not armed");
    property p_mode;
        ctl_wr && !bus_latch_enable && !hv_apply_enable
            |=> erase_mode_hi == $past(ctl_erase_mode_hi) && erase_mode_lo == $past(ctl_erase_mode_lo);
    endproperty
    a_mode: assert property (p_mode) else $error("mode bits not taken");
    c_hv: cover property ($rose(hv_apply_enable));
    c_arm: cover property ($rose(security_armed));
    c_red: cover property (mem_rd && config_shadow_reg[7]);
endmodule // epe_ctrl_asserts

bind epe_ctrl epe_ctrl_asserts u_asserts (.clk(clk), .resetn(resetn), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .ctl_wr(ctl_wr), .ctl_erase_mode_hi(ctl_erase_mode_hi), .ctl_erase_mode_lo(ctl_erase_mode_lo),
    .ctl_bus_latch_enable(ctl_bus_latch_enable), .ctl_hv_apply_enable(ctl_hv_apply_enable), .mem_ack(mem_ack),
    .erase_mode_hi(erase_mode_hi), .erase_mode_lo(erase_mode_lo), .bus_latch_enable(bus_latch_enable),
    .hv_apply_enable(hv_apply_enable), .config_shadow_reg(config_shadow_reg), .security_armed(security_armed));

// ---- verification/tb_epe_ctrl.sv ----
`timescale 1ns/10ps
module tb_epe_ctrl;
    logic clk, resetn, mem_wr, mem_rd, ctl_wr, ctl_hi, ctl_lo, ctl_lat, ctl_hv, mem_ack;
    logic mode_hi, mode_lo, lat, hv, armed, ctl_ref, op_ref, k, r;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata, mem_rdata, shadow, d;
    int          fails, tests_run;
    localparam logic [15:0] NV = epe_pkg::NV_ADDR;

    epe_ctrl u_dut (.clk(clk), .resetn(resetn), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .ctl_wr(ctl_wr), .ctl_erase_mode_hi(ctl_hi), .ctl_erase_mode_lo(ctl_lo),
        .ctl_bus_latch_enable(ctl_lat), .ctl_hv_apply_enable(ctl_hv), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .erase_mode_hi(mode_hi), .erase_mode_lo(mode_lo), .bus_latch_enable(lat), .hv_apply_enable(hv),
        .config_shadow_reg(shadow), .security_armed(armed), .ctl_refused(ctl_ref), .op_refused(op_ref));
    epe_cpu_model cpu (.clk(clk), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .ctl_wr(ctl_wr), .ctl_erase_mode_hi(ctl_hi), .ctl_erase_mode_lo(ctl_lo), .ctl_bus_latch_enable(ctl_lat),
        .ctl_hv_apply_enable(ctl_hv), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .op_refused(op_ref));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic results;
        if (fails == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // rewrite the config byte and load it
    task automatic set_cfg(input logic [7:0] v);
        cpu.op(2'h1, NV, 8'h00, r);
        cpu.op(2'h0, NV, v, r);
        cpu.rd(NV, d, k);
        chk8(shadow, v);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic s_config;
        chk8(shadow, 8'hff);
        cpu.op(2'h0, NV, 8'h10, r);
        chk8(shadow, 8'hff);
        cpu.rd(NV, d, k);
        chk8(d, 8'h10);
        chk8(shadow, 8'h10);
    endtask
    task automatic s_prog;
        cpu.op(2'h0, 16'h0805, 8'h0f, r);
        cpu.rd(16'h0805, d, k);
        chk8(d, 8'h0f);
        cpu.op(2'h0, 16'h0805, 8'hf0, r);
        cpu.rd(16'h0805, d, k);
        chk8(d, 8'h00);
        cpu.op(2'h1, 16'h0805, 8'h00, r);
        cpu.rd(16'h0805, d, k);
        chk8(d, epe_pkg::ERASED);
    endtask
    task automatic s_latch;
        cpu.ctl(2'h0, 1'b1, 1'b0);
        cpu.ctl(2'h0, 1'b0, 1'b0);
        chk1(ctl_ref, 1'b1);
        chk1(lat, 1'b1);
        cpu.wr(16'h0820, 8'h11);
        cpu.wr(16'h0830, 8'h22);
        cpu.wr(16'hfe00, 8'h33);
        cpu.rd(16'h0840, d, k);
        chk8(d, 8'h22);
        cpu.ctl(2'h0, 1'b1, 1'b1);
        chk1(hv, 1'b1);
        cpu.ctl(2'h3, 1'b1, 1'b1);
        chk1(mode_hi | mode_lo, 1'b0);
        cpu.ctl(2'h0, 1'b0, 1'b0);
        chk1(hv, 1'b0);
        chk1(lat, 1'b1);
        cpu.ctl(2'h0, 1'b0, 1'b0);
        cpu.rd(16'h0830, d, k);
        chk8(d, 8'h22);
        cpu.rd(16'h0820, d, k);
        chk8(d, epe_pkg::ERASED);
        cpu.wr(16'hfe00, 8'h00);
        cpu.ctl(2'h0, 1'b0, 1'b1);
        chk1(hv, 1'b0);
    endtask
    task automatic s_block;
        cpu.op(2'h0, 16'h0880, 8'h00, r);
        cpu.op(2'h0, 16'h0900, 8'h00, r);
        cpu.op(2'h2, 16'h08c0, 8'h55, r);
        cpu.rd(16'h0880, d, k);
        chk8(d, epe_pkg::ERASED);
        cpu.rd(16'h0900, d, k);
        chk8(d, 8'h00);
        cpu.op(2'h3, 16'h0801, 8'h00, r);
        cpu.rd(16'h0900, d, k);
        chk8(d, epe_pkg::ERASED);
        cpu.rd(NV, d, k);
        chk8(d, 8'h10);
    endtask
    task automatic s_protect;
        set_cfg(8'h12);
        cpu.op(2'h0, 16'h0880, 8'h00, r);
        chk1(r, 1'b1);
        cpu.rd(16'h0880, d, k);
        chk8(d, epe_pkg::ERASED);
        cpu.op(2'h0, 16'h0800, 8'h00, r);
        chk1(r, 1'b0);
        cpu.op(2'h3, 16'h0800, 8'h00, r);
        chk1(r, 1'b1);
    endtask
    task automatic s_redund;
        set_cfg(8'h98);
        cpu.op(2'h0, 16'h0810, 8'h5a, r);
        cpu.rd(16'h0810, d, k);
        chk8(d, 8'h5a);
        cpu.rd(16'h0910, d, k);
        chk1(k, 1'b0);
        cpu.op(2'h3, 16'h0801, 8'h00, r);
        chk1(r, 1'b0);
        cpu.rd(16'h0810, d, k);
        chk8(d, epe_pkg::ERASED);
    endtask
    task automatic s_secure;
        set_cfg(8'h00);
        chk1(armed, 1'b1);
        cpu.op(2'h0, 16'h08f0, 8'h00, r);
        chk1(r, 1'b1);
        cpu.rd(16'h08f0, d, k);
        chk8({7'h00, k} & d, 8'h01);
        cpu.op(2'h2, 16'h0800, 8'h00, r);
        chk1(r, 1'b1);
        cpu.op(2'h1, 16'h0800, 8'h00, r);
        chk1(r, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #400us;
        fails++;
        results();
    end
    initial begin
        fails = 0;
        tests_run = 0;
        resetn = 1'b0;
        repeat (3) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (2) @(posedge clk);
        s_config();
        s_prog();
        s_latch();
        s_block();
        s_protect();
        s_redund();
        s_secure();
        results();
    end
endmodule // tb_epe_ctrl
